// *** logic/pedw_event_debounce_watchdog.sv ***
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module pedw_event_debounce_watchdog
  import pedw_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire pedw_bus_req_t bus_req,
  output logic [31:0] bus_rdata,
  input wire pedw_levels_t raw_levels,
  input wire pedw_pulses_t event_pulses,
  output pedw_levels_t clean_levels,
  output logic [1:0] pmu_clk_select,
  output logic pmu_domain_reset,
  output logic event_irq
);

  pedw_state_t state;
  pedw_state_t next_state;

  function automatic logic [13:0] long_threshold(input logic [7:0] n);
    long_threshold = {1'b0, n, 5'h00} + LONG_DEB_OFFSET;
  endfunction

  function automatic logic [6:0] divider_period(input logic [4:0] n);
    divider_period = {1'b0, n, 1'b0} + 7'h02;
  endfunction

  // Quadrature lines want a short window, so no shift is applied here.
  function automatic logic [13:0] short_threshold(input logic [7:0] n);
    short_threshold = {6'h00, n} + QDEC_DEB_OFFSET;
  endfunction

  function automatic logic [31:0] widen8(input logic [7:0] v);
    widen8 = {24'h000000, v};
  endfunction

  function automatic logic [31:0] widen16(input logic [15:0] v);
    widen16 = {16'h0000, v};
  endfunction

  function automatic logic [31:0] widen24(input logic [23:0] v);
    widen24 = {8'h00, v};
  endfunction

  logic [FLT_COUNT-1:0] raw_vec;
  logic [FLT_COUNT-1:0] filter_on;
  logic [FLT_COUNT-1:0][13:0] threshold;
  logic [FLT_COUNT-1:0] rise;
  logic [FLT_COUNT-1:0] fall;
  logic [15:0] set_events;
  logic wdt_expire;

  assign raw_vec = raw_levels;

  // A filter that is switched off passes the raw level straight through.
  always_comb
  begin
    filter_on = '1;
    filter_on[FLT_BUTTON] = state.level_enable[LVL_BUTTON_LOW] |
                            state.level_enable[LVL_BUTTON_HIGH];
    filter_on[FLT_CHG_FULL] = state.deb_select[SEL_CHG_FULL_BIT];
    filter_on[FLT_LOW_VOLT] = state.deb_select[SEL_LOW_VOLT_BIT];
    filter_on[FLT_CHARGER] = state.chg_deb[SEL_CHARGER_BIT];
    threshold[FLT_BUTTON] = long_threshold({4'h0, state.btn_key_deb[3:0]});
    // Both analog keys share one window field.
    threshold[FLT_KEY_FIRST] = long_threshold({4'h0, state.btn_key_deb[7:4]});
    threshold[FLT_KEY_SECOND] = long_threshold({4'h0, state.btn_key_deb[7:4]});
    threshold[FLT_QDEC_A] = short_threshold(state.qdec_deb);
    threshold[FLT_QDEC_B] = short_threshold(state.qdec_deb);
    threshold[FLT_QDEC_C] = short_threshold(state.qdec_deb);
    threshold[FLT_CHG_FULL] = long_threshold(state.chg_full_deb);
    threshold[FLT_LOW_VOLT] = long_threshold(state.low_volt_deb);
    threshold[FLT_CHARGER] = long_threshold({2'h0, state.chg_deb[5:0]});
  end

  always_comb
  begin
    next_state = state;
    next_state.rdata = 32'h00000000;
    next_state.domain_reset_pulse = 1'b0;

    // Debounce tick: one mclk-wide pulse every (N+1)*2 cycles.
    next_state.tick = 1'b0;
    if (state.div_count >= divider_period(state.deb_clk_div[7:DEB_DIV_LSB]) - 7'h01)
    begin
      next_state.div_count = 7'h00;
      next_state.tick = 1'b1;
    end
    else
    begin
      next_state.div_count = state.div_count + 7'h01;
    end

    // Any return to the settled level throws the partial count away, so a
    // bouncing input must stay put for the whole time before it is taken.
    for (int i = 0; i < FLT_COUNT; i++)
    begin
      if (!filter_on[i])
      begin
        next_state.clean[i] = raw_vec[i];
        next_state.flt_count[i] = 14'h0000;
      end
      else if (raw_vec[i] == state.clean[i])
      begin
        next_state.flt_count[i] = 14'h0000;
      end
      else if (state.tick)
      begin
        if (state.flt_count[i] + 14'h0001 >= threshold[i])
        begin
          next_state.clean[i] = raw_vec[i];
          next_state.flt_count[i] = 14'h0000;
        end
        else
        begin
          next_state.flt_count[i] = state.flt_count[i] + 14'h0001;
        end
      end
    end
    // Edges come from the filtered levels, so a bounce raises no event unless its filter is switched off.
    rise = next_state.clean & ~state.clean;
    fall = ~next_state.clean & state.clean;

    // Watchdog: counts mclk periods up to the programmed timeout.
    // A zero timeout expires on every cycle, so load the time before starting.
    wdt_expire = 1'b0;
    if (state.event_clear[EV_WATCHDOG])
    begin
      next_state.wdt_count = RST_REG24;
    end
    else if (state.wdt_ctrl[WDT_RUN_BIT])
    begin
      if (state.wdt_count >= state.wdt_time)
      begin
        wdt_expire = 1'b1;
        next_state.wdt_count = RST_REG24;
      end
      else
      begin
        next_state.wdt_count = state.wdt_count + 24'h000001;
      end
    end
    next_state.domain_reset_pulse = wdt_expire & ~state.domain_reset[WDT_NO_RESET_BIT];

    set_events = 16'h0000;
    set_events[EV_CHARGE_FULL] = rise[FLT_CHG_FULL];
    set_events[EV_POWER_OFF] = event_pulses.ultra_low_voltage |
                               event_pulses.button_power_off;
    set_events[EV_LOW_VOLT] = rise[FLT_LOW_VOLT];
    set_events[EV_OVER_TEMP] = event_pulses.over_temp;
    set_events[EV_PLUG_IN] = rise[FLT_CHARGER];
    set_events[EV_CAL_END] = event_pulses.cal_end;
    set_events[EV_PLUG_OUT] = fall[FLT_CHARGER];
    set_events[EV_KEYPAD] = event_pulses.keypad;
    set_events[EV_ALARM_A] = event_pulses.alarm_a;
    set_events[EV_ALARM_B] = event_pulses.alarm_b;
    set_events[EV_WATCHDOG] = wdt_expire & state.wdt_ctrl[WDT_IRQ_BIT];
    set_events[EV_KEY_FIRST] = (fall[FLT_KEY_FIRST] & state.level_enable[LVL_KEY_FIRST_LOW]) |
                               (rise[FLT_KEY_FIRST] &
                                state.level_enable[LVL_KEY_FIRST_HIGH]);
    set_events[EV_KEY_SECOND] = (fall[FLT_KEY_SECOND] &
                                 state.level_enable[LVL_KEY_SECOND_LOW]) |
                                (rise[FLT_KEY_SECOND] &
                                 state.level_enable[LVL_KEY_SECOND_HIGH]);
    set_events[EV_BUTTON] = (fall[FLT_BUTTON] & state.level_enable[LVL_BUTTON_LOW]) |
                            (rise[FLT_BUTTON] & state.level_enable[LVL_BUTTON_HIGH]);
    set_events[EV_EXT_LINE] = event_pulses.ext_line;
    set_events[EV_QDEC] = event_pulses.qdec_event;

    // A new event in the same cycle as a held clear is kept.
    next_state.pending = (state.pending & ~state.event_clear) | set_events;
    next_state.irq = |(next_state.pending & state.event_enable);

    // Narrow registers take the low bits of the write data.
    if (bus_req.wr)
    begin
      case (bus_req.addr)
        ADDR_CLK_CONFIG:
        begin
          next_state.clk_config = bus_req.wdata[7:0];
        end
        ADDR_EVENT_ENABLE:
        begin
          next_state.event_enable = bus_req.wdata[15:0];
        end
        // The clear stays in force until software writes zero again.
        ADDR_EVENT_CLEAR:
        begin
          next_state.event_clear = bus_req.wdata[15:0];
        end
        ADDR_RTC_CONTROL:
        begin
          next_state.rtc_control = bus_req.wdata[7:0];
        end
        ADDR_DEB_CLK_DIV:
        begin
          next_state.deb_clk_div = bus_req.wdata[7:0];
        end
        ADDR_DOMAIN_RESET:
        begin
          next_state.domain_reset = bus_req.wdata[7:0];
        end
        ADDR_DEB_SELECT:
        begin
          next_state.deb_select = bus_req.wdata[7:0];
        end
        ADDR_CHG_DEB:
        begin
          next_state.chg_deb = bus_req.wdata[7:0];
        end
        ADDR_BTN_KEY_DEB:
        begin
          next_state.btn_key_deb = bus_req.wdata[7:0];
        end
        ADDR_LEVEL_ENABLE:
        begin
          next_state.level_enable = bus_req.wdata[7:0];
        end
        ADDR_QDEC_DEB:
        begin
          next_state.qdec_deb = bus_req.wdata[7:0];
        end
        ADDR_WDT_TIME:
        begin
          next_state.wdt_time = bus_req.wdata[23:0];
        end
        ADDR_WDT_CTRL:
        begin
          next_state.wdt_ctrl = bus_req.wdata[7:0];
        end
        ADDR_CHG_FULL_DEB:
        begin
          next_state.chg_full_deb = bus_req.wdata[7:0];
        end
        ADDR_LOW_VOLT_DEB:
        begin
          next_state.low_volt_deb = bus_req.wdata[7:0];
        end
        // Unmapped offsets and the read-only status word ignore writes.
        default:
        begin
          next_state.rdata = 32'h00000000;
        end
      endcase
    end

    // Read data are registered and stand for exactly one cycle.
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        ADDR_CLK_CONFIG:
        begin
          next_state.rdata = widen8(state.clk_config);
        end
        ADDR_EVENT_ENABLE:
        begin
          next_state.rdata = widen16(state.event_enable);
        end
        ADDR_EVENT_CLEAR:
        begin
          next_state.rdata = widen16(state.event_clear);
        end
        ADDR_RTC_CONTROL:
        begin
          next_state.rdata = widen8(state.rtc_control);
        end
        ADDR_DEB_CLK_DIV:
        begin
          next_state.rdata = widen8(state.deb_clk_div);
        end
        ADDR_DOMAIN_RESET:
        begin
          next_state.rdata = widen8(state.domain_reset);
        end
        ADDR_DEB_SELECT:
        begin
          next_state.rdata = widen8(state.deb_select);
        end
        ADDR_CHG_DEB:
        begin
          next_state.rdata = widen8(state.chg_deb);
        end
        ADDR_STATUS:
        begin
          next_state.rdata = widen16(state.pending);
        end
        ADDR_BTN_KEY_DEB:
        begin
          next_state.rdata = widen8(state.btn_key_deb);
        end
        ADDR_LEVEL_ENABLE:
        begin
          next_state.rdata = widen8(state.level_enable);
        end
        ADDR_QDEC_DEB:
        begin
          next_state.rdata = widen8(state.qdec_deb);
        end
        ADDR_WDT_TIME:
        begin
          next_state.rdata = widen24(state.wdt_time);
        end
        ADDR_WDT_CTRL:
        begin
          next_state.rdata = widen8(state.wdt_ctrl);
        end
        ADDR_CHG_FULL_DEB:
        begin
          next_state.rdata = widen8(state.chg_full_deb);
        end
        ADDR_LOW_VOLT_DEB:
        begin
          next_state.rdata = widen8(state.low_volt_deb);
        end
        default:
        begin
          next_state.rdata = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state <= '0;
      state.domain_reset <= RST_DOMAIN_RESET;
      state.event_clear <= RST_REG16;
      state.wdt_time <= RST_REG24;
      state.qdec_deb <= RST_REG8;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign bus_rdata = state.rdata;
  assign clean_levels = state.clean;
  assign pmu_clk_select = state.clk_config[CLK_SEL_LSB +: 2];
  assign pmu_domain_reset = state.domain_reset_pulse;
  assign event_irq = state.irq;

endmodule

// *** logic/pedw_pkg.sv ***
// Functional notes
// - Ultra-low voltage or button power-off sets bit 1.
// - Low voltage bit 2, over-temperature bit 3.
// - Plug-in bit 4, calibration bit 5, plug-out 6.
// - Keypad bit 7, alarms at bits 8 and 9.
// - Watchdog expiry pending at bit 10 until cleared.
// - Analog keys bits 11, 12; power button 13.
// - External line bit 14, quadrature bit 15.
// - Clear bit held at one clears pending flag.
// - Clearing watchdog flag also reloads watchdog counter.
// - Debounce tick divides clock by (N+1)*2.
// - Level-mode button filter (N<<5)+9 ticks, bits 3:0.
// - Analog key filter (N<<5)+9 ticks, bits 7:4.
// - Quadrature filter (2+N) ticks, bits 7:0.
// - Charge-full filter (N<<5)+9 ticks, bits 7:0.
// - Low-voltage filter (N<<5)+9 ticks, own field.
// - Charger detect filter (N<<5)+9 ticks, bits 5:0.
// - Watchdog timeout is 24 bits of clock periods.
// - Watchdog control bit 0 runs the counter.
// - Watchdog control bit 1 enables expiry event.
// - Expiry resets domain unless reset-control bit 1 set.
// - Two-bit field selects the system clock source.
// - Pending event forwarded only when enabled.
package pedw_pkg;

  localparam logic [7:0] ADDR_CLK_CONFIG = 8'h37;
  localparam logic [7:0] ADDR_EVENT_ENABLE = 8'h3A;
  localparam logic [7:0] ADDR_EVENT_CLEAR = 8'h3B;
  localparam logic [7:0] ADDR_RTC_CONTROL = 8'h3D;
  localparam logic [7:0] ADDR_DEB_CLK_DIV = 8'h54;
  localparam logic [7:0] ADDR_DOMAIN_RESET = 8'h56;
  localparam logic [7:0] ADDR_DEB_SELECT = 8'h68;
  localparam logic [7:0] ADDR_CHG_DEB = 8'h6D;
  localparam logic [7:0] ADDR_STATUS = 8'h70;
  localparam logic [7:0] ADDR_BTN_KEY_DEB = 8'h79;
  localparam logic [7:0] ADDR_LEVEL_ENABLE = 8'h7A;
  localparam logic [7:0] ADDR_QDEC_DEB = 8'h7B;
  localparam logic [7:0] ADDR_WDT_TIME = 8'hB0;
  localparam logic [7:0] ADDR_WDT_CTRL = 8'hB3;
  localparam logic [7:0] ADDR_CHG_FULL_DEB = 8'hCE;
  localparam logic [7:0] ADDR_LOW_VOLT_DEB = 8'hCF;

  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic [15:0] RST_REG16 = 16'h0000;
  localparam logic [23:0] RST_REG24 = 24'h000000;
  localparam logic [7:0] RST_DOMAIN_RESET = 8'h00;

  localparam int EV_CHARGE_FULL = 0;
  localparam int EV_POWER_OFF = 1;
  localparam int EV_LOW_VOLT = 2;
  localparam int EV_OVER_TEMP = 3;
  localparam int EV_PLUG_IN = 4;
  localparam int EV_CAL_END = 5;
  localparam int EV_PLUG_OUT = 6;
  localparam int EV_KEYPAD = 7;
  localparam int EV_ALARM_A = 8;
  localparam int EV_ALARM_B = 9;
  localparam int EV_WATCHDOG = 10;
  localparam int EV_KEY_FIRST = 11;
  localparam int EV_KEY_SECOND = 12;
  localparam int EV_BUTTON = 13;
  localparam int EV_EXT_LINE = 14;
  localparam int EV_QDEC = 15;

  localparam int DEB_DIV_LSB = 3;
  localparam int CLK_SEL_LSB = 6;
  localparam int WDT_RUN_BIT = 0;
  localparam int WDT_IRQ_BIT = 1;
  localparam int WDT_NO_RESET_BIT = 1;
  localparam int SEL_CHG_FULL_BIT = 6;
  localparam int SEL_LOW_VOLT_BIT = 7;
  localparam int SEL_CHARGER_BIT = 6;
  localparam int LVL_BUTTON_LOW = 0;
  localparam int LVL_BUTTON_HIGH = 1;
  localparam int LVL_KEY_FIRST_LOW = 2;
  localparam int LVL_KEY_FIRST_HIGH = 3;
  localparam int LVL_KEY_SECOND_LOW = 4;
  localparam int LVL_KEY_SECOND_HIGH = 5;
  localparam logic [13:0] LONG_DEB_OFFSET = 14'h0009;
  localparam logic [13:0] QDEC_DEB_OFFSET = 14'h0002;

  localparam int FLT_BUTTON = 0;
  localparam int FLT_KEY_FIRST = 1;
  localparam int FLT_KEY_SECOND = 2;
  localparam int FLT_QDEC_A = 3;
  localparam int FLT_QDEC_B = 4;
  localparam int FLT_QDEC_C = 5;
  localparam int FLT_CHG_FULL = 6;
  localparam int FLT_LOW_VOLT = 7;
  localparam int FLT_CHARGER = 8;
  localparam int FLT_COUNT = 9;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pedw_bus_req_t;

  // Order matches the FLT_ indices, lowest index in the lowest bit.
  typedef struct packed {
    logic charger_present;
    logic low_voltage;
    logic charge_full;
    logic [2:0] qdec_line;
    logic analog_button_second;
    logic analog_button_first;
    logic power_button;
  } pedw_levels_t;

  typedef struct packed {
    logic ultra_low_voltage;
    logic button_power_off;
    logic over_temp;
    logic cal_end;
    logic keypad;
    logic alarm_a;
    logic alarm_b;
    logic ext_line;
    logic qdec_event;
  } pedw_pulses_t;

  typedef struct packed {
    logic [7:0] clk_config;
    logic [7:0] rtc_control;
    logic [7:0] deb_clk_div;
    logic [7:0] domain_reset;
    logic [7:0] deb_select;
    logic [7:0] chg_deb;
    logic [7:0] btn_key_deb;
    logic [7:0] level_enable;
    logic [7:0] qdec_deb;
    logic [7:0] wdt_ctrl;
    logic [7:0] chg_full_deb;
    logic [7:0] low_volt_deb;
    logic [15:0] event_enable;
    logic [15:0] event_clear;
    logic [15:0] pending;
    logic [23:0] wdt_time;
    logic [23:0] wdt_count;
    logic [6:0] div_count;
    logic tick;
    logic [FLT_COUNT-1:0] clean;
    logic [FLT_COUNT-1:0][13:0] flt_count;
    logic domain_reset_pulse;
    logic irq;
    logic [31:0] rdata;
  } pedw_state_t;

endpackage

// *** tb/pedw_far_side.sv ***
`timescale 1ns/1ps
module pedw_far_side
  import pedw_pkg::*;
(
  input wire logic mclk,
  output pedw_levels_t raw_levels,
  output pedw_pulses_t event_pulses
);
  // Detectors are already synchronised, so they only move just after an edge.
  initial
  begin
    raw_levels = '0;
    event_pulses = '0;
  end
  task automatic pulse(input int idx);
    @(posedge mclk);
    event_pulses[idx] <= 1'b1;
    @(posedge mclk);
    event_pulses[idx] <= 1'b0;
  endtask
  task automatic set_levels(input pedw_levels_t lv);
    @(posedge mclk);
    raw_levels <= lv;
  endtask
endmodule

// *** tb/pedw_monitor.sv ***
`timescale 1ns/1ps
module pedw_monitor
  import pedw_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire pedw_bus_req_t bus_req,
  input wire logic [31:0] bus_rdata,
  input wire pedw_levels_t raw_levels,
  input wire pedw_pulses_t event_pulses,
  input wire pedw_levels_t clean_levels,
  input wire logic [1:0] pmu_clk_select,
  input wire logic pmu_domain_reset,
  input wire logic event_irq
);
  default clocking dck @(posedge mclk); endclocking
  default disable iff (rst);
  logic [15:0] en_sh;
  logic [7:0] dr_sh;
  logic [7:0] wc_sh;
  // Shadows rebuilt from bus writes alone, so no internal state is peeked.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      en_sh <= 16'h0000;
      dr_sh <= 8'h00;
      wc_sh <= 8'h00;
    end
    else if (bus_req.wr)
    begin
      if (bus_req.addr == ADDR_EVENT_ENABLE)
        en_sh <= bus_req.wdata[15:0];
      if (bus_req.addr == ADDR_DOMAIN_RESET)
        dr_sh <= bus_req.wdata[7:0];
      if (bus_req.addr == ADDR_WDT_CTRL)
        wc_sh <= bus_req.wdata[7:0];
    end
  end
  sequence s_sel_write;
    bus_req.wr && bus_req.addr == ADDR_CLK_CONFIG;
  endsequence
  a_rdata_idle:
    assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h00000000)
    else $error("read data not zero outside read answer");
  a_unmapped_read:
    assert property (bus_req.rd && bus_req.addr == 8'h01 |=> bus_rdata == 32'h00000000)
    else $error("unmapped read returned data");
  a_clock_select:
    assert property (s_sel_write |-> ##2 pmu_clk_select == $past(bus_req.wdata[7:6], 2))
    else $error("clock select does not follow register");
  a_pulse_irq:
    assert property (event_pulses.over_temp && en_sh[EV_OVER_TEMP] |-> ##2 event_irq)
    else $error("enabled event did not raise interrupt");
  a_irq_masked:
    assert property (en_sh == 16'h0000 && $past(en_sh) == 16'h0000 |-> !event_irq)
    else $error("interrupt with all enables off");
  a_reset_one_cycle:
    assert property (pmu_domain_reset |=> !pmu_domain_reset)
    else $error("domain reset longer than one cycle");
  a_reset_suppressed:
    assert property ($past(dr_sh[WDT_NO_RESET_BIT]) && $past(dr_sh[WDT_NO_RESET_BIT], 3)
      |-> !pmu_domain_reset)
    else $error("domain reset while suppressed");
  a_watchdog_stopped:
    assert property (!wc_sh[WDT_RUN_BIT] && !$past(wc_sh[WDT_RUN_BIT], 3) |-> !pmu_domain_reset)
    else $error("domain reset with watchdog stopped");
  a_qdec_stable:
    assert property ($changed(clean_levels.qdec_line)
      |-> ((clean_levels.qdec_line ^ $past(clean_levels.qdec_line))
        & ($past(raw_levels.qdec_line) ^ $past(raw_levels.qdec_line, 2))) == 3'b000)
    else $error("quadrature level passed without being stable");
  a_charge_follows:
    assert property ($changed(clean_levels.charge_full)
      |-> clean_levels.charge_full == $past(raw_levels.charge_full))
    else $error("charge full level moved away from raw input");
endmodule
bind pedw_event_debounce_watchdog pedw_monitor mon_u (.mclk(mclk), .rst(rst),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .raw_levels(raw_levels),
  .event_pulses(event_pulses), .clean_levels(clean_levels),
  .pmu_clk_select(pmu_clk_select), .pmu_domain_reset(pmu_domain_reset),
  .event_irq(event_irq));

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench import pedw_pkg::*;;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  pedw_bus_req_t bus_req = '0;
  logic [31:0] bus_rdata;
  pedw_levels_t raw_levels;
  pedw_pulses_t event_pulses;
  pedw_levels_t clean_levels;
  logic [1:0] pmu_clk_select;
  logic pmu_domain_reset;
  logic event_irq;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int resets_seen = 0;
  int bit_of[9] = '{15, 14, 9, 8, 7, 5, 3, 1, 1};
  always #2 mclk = ~mclk;
  pedw_event_debounce_watchdog dut_u (.mclk(mclk), .rst(rst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .raw_levels(raw_levels), .event_pulses(event_pulses),
    .clean_levels(clean_levels), .pmu_clk_select(pmu_clk_select),
    .pmu_domain_reset(pmu_domain_reset), .event_irq(event_irq));
  pedw_far_side far_u (.mclk(mclk), .raw_levels(raw_levels), .event_pulses(event_pulses));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus_req <= {a, d, 1'b1, 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge mclk);
    bus_req <= {a, 32'h00000000, 1'b0, 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1 check(bus_rdata, exp, what);
  endtask
  task automatic clr(input int b);
    wr(ADDR_EVENT_CLEAR, 32'h1 << b);
    repeat (2) @(posedge mclk);
    wr(ADDR_EVENT_CLEAR, 32'h0);
  endtask
  task automatic flt(input pedw_levels_t lv, input int early, input int late, input int sb);
    pedw_levels_t old;
    old = clean_levels;
    far_u.set_levels(lv);
    repeat (early) @(posedge mclk);
    #1 check(32'(clean_levels), 32'(old), "filter passed early");
    repeat (late - early) @(posedge mclk);
    #1 check(32'(clean_levels), 32'(lv), "filter never passed");
    if (sb >= 0)
    begin
      rchk(ADDR_STATUS, 32'h1 << sb, "level event pending");
      clr(sb);
    end
  endtask
  task automatic wdt_count(input int waitc, input int exp, input string what);
    int base;
    #1 base = resets_seen;
    repeat (waitc) @(posedge mclk);
    #1 check(32'(resets_seen - base), 32'(exp), what);
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (pmu_domain_reset === 1'b1)
      resets_seen++;
    if (cycles == 20000)
    begin
      bad_count++;
      report_and_stop();
    end
  end
  initial
  begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    rchk(ADDR_QDEC_DEB, 32'h0, "qdec debounce reset");
    rchk(ADDR_CHG_FULL_DEB, 32'h0, "charge full debounce reset");
    rchk(ADDR_LOW_VOLT_DEB, 32'h0, "low voltage debounce reset");
    rchk(ADDR_WDT_TIME, 32'h0, "watchdog time reset");
    rchk(8'h01, 32'h0, "unmapped read");
    wr(ADDR_WDT_TIME, 32'hFFFFFFFF);
    rchk(ADDR_WDT_TIME, 32'h00FFFFFF, "watchdog time width");
    for (int c = 0; c < 4; c++)
    begin
      wr(ADDR_CLK_CONFIG, 32'(c) << 6);
      @(posedge mclk);
      #1 check(32'(pmu_clk_select), 32'(c), "clock select");
    end
    $display("test registers done");
    for (int i = 0; i < 9; i++)
    begin
      far_u.pulse(i);
      rchk(ADDR_STATUS, 32'h1 << bit_of[i], "pulse pending");
      clr(bit_of[i]);
      rchk(ADDR_STATUS, 32'h0, "pending cleared");
    end
    wr(ADDR_EVENT_ENABLE, 32'h8);
    far_u.pulse(6);
    repeat (2) @(posedge mclk);
    #1 check(32'(event_irq), 32'h1, "enabled interrupt");
    clr(EV_OVER_TEMP);
    repeat (2) @(posedge mclk);
    #1 check(32'(event_irq), 32'h0, "interrupt after clear");
    wr(ADDR_EVENT_ENABLE, 32'h0);
    far_u.pulse(6);
    repeat (3) @(posedge mclk);
    #1 check(32'(event_irq), 32'h0, "masked interrupt");
    clr(EV_OVER_TEMP);
    $display("test events done");
    wr(ADDR_DEB_CLK_DIV, 32'h0);
    wr(ADDR_QDEC_DEB, 32'h1);
    flt(9'h008, 3, 15, -1);
    far_u.set_levels(9'h000);
    flt(9'h008, 3, 20, -1);
    wr(ADDR_DEB_CLK_DIV, 32'h8);
    wr(ADDR_QDEC_DEB, 32'h0);
    flt(9'h000, 3, 12, -1);
    wr(ADDR_DEB_CLK_DIV, 32'h0);
    wr(ADDR_DEB_SELECT, 32'hC0);
    wr(ADDR_CHG_DEB, 32'h40);
    wr(ADDR_LEVEL_ENABLE, 32'h0A);
    flt(9'h040, 15, 30, EV_CHARGE_FULL);
    flt(9'h0C0, 15, 30, EV_LOW_VOLT);
    flt(9'h1C0, 15, 30, EV_PLUG_IN);
    flt(9'h0C0, 15, 30, EV_PLUG_OUT);
    flt(9'h0C1, 15, 30, EV_BUTTON);
    flt(9'h0C3, 15, 30, EV_KEY_FIRST);
    wr(ADDR_LEVEL_ENABLE, 32'h25);
    flt(9'h0C2, 15, 30, EV_BUTTON);
    flt(9'h0C0, 15, 30, EV_KEY_FIRST);
    flt(9'h0C4, 15, 30, EV_KEY_SECOND);
    wr(ADDR_CHG_FULL_DEB, 32'h1);
    flt(9'h084, 78, 100, -1);
    $display("test filters done");
    wr(ADDR_WDT_TIME, 32'h28);
    wr(ADDR_WDT_CTRL, 32'h3);
    wdt_count(30, 0, "watchdog fired early");
    wdt_count(20, 1, "watchdog reset count");
    rchk(ADDR_STATUS, 32'h400, "watchdog pending");
    wr(ADDR_EVENT_CLEAR, 32'h400);
    wdt_count(100, 0, "watchdog fed while clear held");
    rchk(ADDR_STATUS, 32'h0, "watchdog pending cleared");
    wr(ADDR_EVENT_CLEAR, 32'h0);
    wdt_count(30, 0, "watchdog not reloaded");
    wdt_count(20, 1, "watchdog after feed");
    wr(ADDR_EVENT_CLEAR, 32'h400);
    wr(ADDR_WDT_CTRL, 32'h0);
    wr(ADDR_EVENT_CLEAR, 32'h0);
    wdt_count(100, 0, "stopped watchdog");
    wr(ADDR_DOMAIN_RESET, 32'h2);
    wr(ADDR_WDT_CTRL, 32'h1);
    wdt_count(100, 0, "suppressed domain reset");
    rchk(ADDR_STATUS, 32'h0, "watchdog event disabled");
    wr(ADDR_WDT_CTRL, 32'h0);
    $display("test watchdog done");
    report_and_stop();
  end
endmodule
